//--- design/cbc_core.sv
// bus-cycle sequencer with effective-address generation
// assumes memory on the same clock answers mem_rdata_i in the bus cycle
//
// Strobed register access and the register addresses were chosen for this implementation.
`include "cbc_defines.svh"

module cbc_core
    import cbc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // register port
    input  wire logic [2:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // cycle requests
    input  wire logic        cmd_valid_i,
    input  wire cbc_cmd_t    cmd_i,
    // system memory bus
    output cbc_bus_t         mem_o,
    input  wire logic [7:0]  mem_rdata_i,
    // read results
    output logic             rsp_valid_o,
    output logic [7:0]       rsp_data_o
);

    // architectural state
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0]  idx_upper;
    logic [7:0]  idx_lower;
    logic [7:0]  condition_flags_reg;
    logic [15:0] last_ea;
    logic [15:0] cycle_count;
    // pipeline of one bus cycle
    cbc_bus_t    bus;
    logic        capture;
    logic        cap_vec_hi;
    logic        cap_vec_lo;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic [15:0] reg_rdata;

    // next values
    // two combinational processes compute them, registered below in three groups
    logic [15:0] next_pc;
    logic [15:0] next_sp;
    logic [7:0]  next_idx_upper;
    logic [7:0]  next_idx_lower;
    logic [7:0]  next_condition_flags_reg;
    logic [15:0] next_last_ea;
    logic [15:0] next_cycle_count;
    cbc_bus_t    next_bus;
    logic        next_capture;
    logic        next_vec_hi;
    logic        next_vec_lo;
    logic        next_rsp_valid;
    logic [7:0]  next_rsp_data;
    logic [15:0] next_reg_rdata;

    logic [15:0] index;
    assign index = {idx_upper, idx_lower};

    // effective address of an operand cycle; used for reads and writes
    function automatic logic [15:0] eff_addr(input cbc_mode_t   mode,
                                             input logic [15:0] opnd,
                                             input logic [15:0] hx,
                                             input logic [15:0] stk,
                                             input logic [15:0] prog);
        logic [15:0] ea;
        ea = prog;
        case (mode)
            // operand sits right after the opcode
            immediate_mode: ea = prog;
            // direct page is the bottom page of memory
            direct_mode: ea = {`CBC_DIR_PAGE, opnd[7:0]};
            extended_mode: ea = opnd;
            // plain index, nothing added
            indexed_mode: ea = hx;
            indexed_postinc_mode: ea = hx;
            indexed_offset_postinc_mode: ea = hx + {8'h00, opnd[7:0]};
            // short offset without the index step
            indexed_short_offset_mode: ea = hx + {8'h00, opnd[7:0]};
            indexed_long_offset_mode: ea = hx + opnd;
            stack_short_offset_mode: ea = stk + {8'h00, opnd[7:0]};
            stack_long_offset_mode: ea = stk + opnd;
            default: ea = prog;
        endcase
        return ea;
    endfunction

    // true for modes that bump the index after the access
    // shared by reads and writes so both step the index alike
    function automatic logic post_inc(input cbc_mode_t mode);
        return (mode == indexed_postinc_mode) || (mode == indexed_offset_postinc_mode);
    endfunction

    // cycle sequencing and address generation
    always_comb begin
        logic [15:0] ea;
        logic [15:0] hx_inc;
        ea                       = eff_addr(cmd_i.mode, cmd_i.operand, index, sp, pc);
        hx_inc                   = index + 16'h0001;
        next_pc                  = pc;
        next_sp                  = sp;
        next_idx_upper           = idx_upper;
        next_idx_lower           = idx_lower;
        next_condition_flags_reg = condition_flags_reg;
        next_last_ea             = last_ea;
        next_cycle_count         = cycle_count;
        next_bus                 = '{addr: pc, wdata: 8'h00, rd: 1'b0, wr: 1'b0};
        next_capture             = 1'b0;
        next_vec_hi              = 1'b0;
        next_vec_lo              = 1'b0;
        if (cmd_valid_i) begin
            next_cycle_count = cycle_count + 16'h0001;
            case (cmd_i.kind)
                CBC_FREE: begin
                    // one clock, no transfer, read strobe
                    // no capture: whatever memory drives is ignored
                    next_bus.rd = 1'b1;
                    if (cmd_i.mode == relative_mode) begin
                        next_pc = pc + {{8{cmd_i.operand[7]}}, cmd_i.operand[7:0]};
                    end
                end
                CBC_FETCH: begin
                    // next sequential program byte
                    // pc steps past the fetched byte, ready for the next fetch
                    next_bus.addr = pc;
                    next_bus.rd   = 1'b1;
                    next_capture  = 1'b1;
                    next_pc       = pc + 16'h0001;
                end
                CBC_READ: begin
                    next_bus.addr = ea;
                    // inherent mode moves no byte: shown as a free read cycle
                    next_bus.rd   = 1'b1;
                    next_capture  = (cmd_i.mode != inherent_mode);
                    next_last_ea  = ea;
                    if (cmd_i.mode == immediate_mode) begin
                        next_pc = pc + 16'h0001;
                    end
                    if (post_inc(cmd_i.mode)) begin
                        {next_idx_upper, next_idx_lower} = hx_inc;
                    end
                end
                CBC_WRITE: begin
                    // one byte out of the core, except inherent mode, which runs a free read cycle
                    next_bus.addr  = ea;
                    next_bus.wdata = cmd_i.wdata;
                    next_bus.wr    = (cmd_i.mode != inherent_mode);
                    next_bus.rd    = (cmd_i.mode == inherent_mode);
                    next_last_ea   = ea;
                    if (post_inc(cmd_i.mode)) begin
                        {next_idx_upper, next_idx_lower} = hx_inc;
                    end
                end
                CBC_PUSH: begin
                    // pointer names the free slot below the last pushed byte
                    // one byte to the stack
                    next_bus.addr  = sp;
                    next_bus.wdata = cmd_i.wdata;
                    next_bus.wr    = 1'b1;
                    next_sp        = sp - 16'h0001;
                end
                CBC_POP: begin
                    next_sp       = sp + 16'h0001;
                    next_bus.addr = sp + 16'h0001;
                    next_bus.rd   = 1'b1;
                    next_capture  = 1'b1;
                end
                CBC_VEC_HI: begin
                    // upper byte from top page first
                    next_bus.addr = {`CBC_VEC_PAGE, cmd_i.operand[7:1], 1'b0};
                    next_bus.rd   = 1'b1;
                    next_capture  = 1'b1;
                    next_vec_hi   = 1'b1;
                end
                CBC_VEC_LO: begin
                    next_bus.addr = {`CBC_VEC_PAGE, cmd_i.operand[7:1], 1'b1};
                    next_bus.rd   = 1'b1;
                    next_capture  = 1'b1;
                    next_vec_lo   = 1'b1;
                end
                default: next_bus.rd = 1'b1;
            endcase
        end
        // vector bytes land in the program counter a cycle after the bus cycle
        // limitation: a fetch placed right after a low vector cycle loses its pc step
        if (cap_vec_hi) begin
            next_pc[15:8] = mem_rdata_i;
        end
        if (cap_vec_lo) begin
            next_pc[7:0] = mem_rdata_i;
        end
        // software writes win over the sequencer in the same cycle
        // a write to the last-address slot is ignored on purpose
        if (reg_wr_i) begin
            case (reg_addr_i)
                `CBC_REG_PC: next_pc = reg_wdata_i;
                `CBC_REG_SP: next_sp = reg_wdata_i;
                `CBC_REG_HX: {next_idx_upper, next_idx_lower} = reg_wdata_i;
                // six flags writable, fixed ones forced
                `CBC_REG_FLAGS: next_condition_flags_reg =
                    (reg_wdata_i[7:0] & `CBC_FLAGS_WMASK) | `CBC_FLAGS_ONES;
                `CBC_REG_COUNT: next_cycle_count = 16'h0000;
                default: next_pc = next_pc;
            endcase
        end
    end

    // read results and register read data
    always_comb begin
        next_rsp_valid = capture;
        next_rsp_data  = capture ? mem_rdata_i : rsp_data;
        next_reg_rdata = 16'h0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `CBC_REG_PC: next_reg_rdata = pc;
                `CBC_REG_SP: next_reg_rdata = sp;
                `CBC_REG_HX: next_reg_rdata = index;
                `CBC_REG_FLAGS: next_reg_rdata = {8'h00, condition_flags_reg};
                `CBC_REG_EA: next_reg_rdata = last_ea;
                `CBC_REG_COUNT: next_reg_rdata = cycle_count;
                // reads outside the map return zero
                default: next_reg_rdata = 16'h0000;
            endcase
        end
    end

    // architectural state; synchronous reset keeps everything on one clock
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pc                  <= `CBC_PC_RST;
            sp                  <= `CBC_SP_RST;
            idx_upper           <= 8'(`CBC_HX_RST >> 8);
            idx_lower           <= 8'(`CBC_HX_RST);
            condition_flags_reg <= `CBC_FLAGS_RST;
            last_ea             <= 16'h0000;
            cycle_count         <= 16'h0000;
        end else begin
            pc                  <= next_pc;
            sp                  <= next_sp;
            idx_upper           <= next_idx_upper;
            idx_lower           <= next_idx_lower;
            condition_flags_reg <= next_condition_flags_reg;
            last_ea             <= next_last_ea;
            cycle_count         <= next_cycle_count;
        end
    end

    // bus pipeline; strobes drop so memory sees no stale cycle after reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bus                 <= '{addr: 16'h0000, wdata: 8'h00, rd: 1'b0, wr: 1'b0};
            capture             <= 1'b0;
            cap_vec_hi          <= 1'b0;
            cap_vec_lo          <= 1'b0;
        end else begin
            bus                 <= next_bus;
            capture             <= next_capture;
            cap_vec_hi          <= next_vec_hi;
            cap_vec_lo          <= next_vec_lo;
        end
    end

    // read results and register read data
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rsp_valid           <= 1'b0;
            rsp_data            <= 8'h00;
            reg_rdata           <= 16'h0000;
        end else begin
            rsp_valid           <= next_rsp_valid;
            rsp_data            <= next_rsp_data;
            reg_rdata           <= next_reg_rdata;
        end
    end

    // outputs straight from flip-flops
    // no logic between the flops and the pins, so output timing stays clean
    assign mem_o       = bus;
    assign rsp_valid_o = rsp_valid;
    assign rsp_data_o  = rsp_data;
    assign reg_rdata_o = reg_rdata;

endmodule

//--- common/cbc_defines.svh
// constants for the bus-cycle and addressing block
// assumes one 100 MHz clock and a plain register port
`ifndef CBC_DEFINES_SVH
`define CBC_DEFINES_SVH

// register port word offsets
`define CBC_REG_PC        3'h0
`define CBC_REG_SP        3'h1
`define CBC_REG_HX        3'h2
`define CBC_REG_FLAGS     3'h3
`define CBC_REG_EA        3'h4
`define CBC_REG_COUNT     3'h5

// reset values
`define CBC_PC_RST        16'h0000
`define CBC_SP_RST        16'h00ff
`define CBC_HX_RST        16'h0000
`define CBC_FLAGS_RST     8'h68

// flag bit positions; bits 6 and 5 always read one
`define CBC_FLAG_V        7
`define CBC_FLAG_H        4
`define CBC_FLAG_I        3
`define CBC_FLAG_N        2
`define CBC_FLAG_Z        1
`define CBC_FLAG_C        0
`define CBC_FLAGS_ONES    8'h60
`define CBC_FLAGS_WMASK   8'h9f

// top page of memory holding vectors, bottom page for direct mode
`define CBC_VEC_PAGE      8'hff
`define CBC_DIR_PAGE      8'h00

`endif

//--- common/cbc_pkg.sv
// types for the bus-cycle and addressing block
// assumes cbc_defines.svh supplies the numeric constants
package cbc_pkg;

    // kinds of bus cycle the sequencer can run
    typedef enum logic [2:0] {
        CBC_FREE,
        CBC_FETCH,
        CBC_READ,
        CBC_WRITE,
        CBC_PUSH,
        CBC_POP,
        CBC_VEC_HI,
        CBC_VEC_LO
    } cbc_kind_t;

    // addressing modes for operand cycles
    typedef enum logic [3:0] {
        inherent_mode,
        immediate_mode,
        direct_mode,
        extended_mode,
        indexed_mode,
        indexed_short_offset_mode,
        indexed_long_offset_mode,
        indexed_postinc_mode,
        indexed_offset_postinc_mode,
        stack_short_offset_mode,
        stack_long_offset_mode,
        relative_mode
    } cbc_mode_t;

    // one cycle request from the sequencer's user
    typedef struct packed {
        cbc_kind_t   kind;
        cbc_mode_t   mode;
        logic [15:0] operand;
        logic [7:0]  wdata;
    } cbc_cmd_t;

    // one cycle on the system memory bus
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } cbc_bus_t;

endpackage

//--- test/cbc_core_chk.sv
// port checker for the bus-cycle sequencer
// assumes one clock and a synchronous active-high reset
module cbc_core_chk
    import cbc_pkg::*;
(
    // clock and reset
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    // watched ports
    input wire logic       reg_wr_i,
    input wire logic       cmd_valid_i,
    input wire cbc_cmd_t   cmd_i,
    input wire cbc_bus_t   mem_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic       rsp_valid_o,
    input wire logic [7:0] rsp_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // a register write overrides pointer updates, so pairs exclude it
    sequence s_two(cbc_kind_t k);
        (cmd_valid_i && cmd_i.kind == k && !reg_wr_i) [*2];
    endsequence
    sequence s_inc_two;
        (cmd_valid_i && cmd_i.kind == CBC_READ && cmd_i.mode == indexed_postinc_mode && !reg_wr_i) [*2];
    endsequence
    a_free_is_read: assert property (cmd_valid_i && cmd_i.kind == CBC_FREE |=> mem_o.rd && !mem_o.wr)
        else $error("free cycle not a single read");
    a_fetch_next: assert property (s_two(CBC_FETCH) |=> mem_o.addr == $past(mem_o.addr) + 16'h0001)
        else $error("fetch address not sequential");
    a_read_result: assert property (cmd_valid_i && cmd_i.kind == CBC_READ && cmd_i.mode != inherent_mode
        |=> mem_o.rd ##1 rsp_valid_o && rsp_data_o == $past(mem_rdata_i))
        else $error("operand read byte lost");
    a_write_out: assert property (cmd_valid_i && cmd_i.kind == CBC_WRITE && cmd_i.mode != inherent_mode
        |=> mem_o.wr && !mem_o.rd && mem_o.wdata == $past(cmd_i.wdata))
        else $error("operand write byte wrong");
    a_push_down: assert property (s_two(CBC_PUSH) |=> mem_o.wr && mem_o.addr == $past(mem_o.addr) - 16'h0001)
        else $error("push address not descending");
    a_pop_up: assert property (s_two(CBC_POP) |=> mem_o.rd && mem_o.addr == $past(mem_o.addr) + 16'h0001)
        else $error("pop address not ascending");
    a_vec_top: assert property (cmd_valid_i && cmd_i.kind == CBC_VEC_HI
        |=> mem_o.rd && mem_o.addr == {8'hff, $past(cmd_i.operand[7:1]), 1'b0})
        else $error("vector high byte address wrong");
    a_postinc_step: assert property (s_inc_two |=> mem_o.addr == $past(mem_o.addr) + 16'h0001)
        else $error("post-increment did not step index");
endmodule

bind cbc_core cbc_core_chk chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));

//--- test/cbc_mem_model.sv
// memory partner answering reads in the bus cycle
// assumes content is a fixed pattern of the address
module cbc_mem_model
    import cbc_pkg::*;
(
    input  wire logic     clk_i,
    input  wire cbc_bus_t mem_i,
    output logic    [7:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last = 8'h00;
    // idle bus toggles so a stale byte never looks valid
    always_comb begin
        if (mem_i.rd) begin
            rdata_o = mem_i.addr[7:0] ^ mem_i.addr[15:8] ^ 8'h5a;
        end else begin
            rdata_o = ~last;
        end
    end
    always @(posedge clk_i) begin
        last <= rdata_o;
    end
endmodule

//--- test/tb_top.sv
// self-checking bench for the bus-cycle sequencer
// assumes the checker binds itself and the model answers reads
module tb_top
    import cbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {cbc_mode_t m; logic [15:0] op; logic [15:0] ea;} cbc_row_t;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [2:0]  reg_addr_i = 3'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic        cmd_valid_i = 1'b0;
    cbc_cmd_t    cmd_i = '0;
    cbc_bus_t    mem_o;
    logic [7:0]  mem_rdata_i;
    logic        rsp_valid_o;
    logic [7:0]  rsp_data_o;
    int          bad_count = 0;
    int          checks_done = 0;
    logic [15:0] rv;
    logic [15:0] pc;
    cbc_bus_t    bs;
    logic [8:0]  rs;
    // hx is 1230 and sp 00ff when these run
    cbc_row_t    rows [8] = '{'{direct_mode, 16'h0042, 16'h0042}, '{extended_mode, 16'habcd, 16'habcd},
        '{indexed_mode, 16'h0000, 16'h1230}, '{indexed_short_offset_mode, 16'hff80, 16'h12b0},
        '{indexed_long_offset_mode, 16'hf000, 16'h0230}, '{stack_short_offset_mode, 16'h00ff, 16'h01fe},
        '{stack_long_offset_mode, 16'hff01, 16'h0000}, '{immediate_mode, 16'h0000, 16'h0000}};
    always #5 clk_i = ~clk_i;
    cbc_core dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
    cbc_mem_model mem (.clk_i(clk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d, checks %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [2:0] a);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 rv = reg_rdata_o;
    endtask
    // one cycle request; bus seen one edge later, result two
    task automatic run(input cbc_kind_t k, input cbc_mode_t m, input logic [15:0] op, input logic [7:0] wd);
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_i <= '{k, m, op, wd};
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        #1 bs = mem_o;
        @(posedge clk_i);
        #1 rs = {rsp_valid_o, rsp_data_o};
    endtask
    task automatic burst(input cbc_kind_t k, input cbc_mode_t m, input int n);
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_i <= '{k, m, 16'h0000, 8'h3c};
        repeat (n) @(posedge clk_i);
        cmd_valid_i <= 1'b0;
    endtask
    // watchdog far beyond the some 140 cycles the tests take
    initial begin
        #100000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1 check("idle strobes", {mem_o.rd, mem_o.wr, rsp_valid_o}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            reg_rd(3'(i));
            check("reset reg", rv, i == 1 ? 16'h00ff : (i == 3 ? 16'h0068 : 16'h0000));
        end
        reg_rd(3'h6);
        check("unmapped", rv, 16'h0000);
        reg_wr(3'h3, 16'h0000);
        reg_rd(3'h3);
        check("flags clear", rv, 16'h0060);
        reg_wr(3'h3, 16'h009f);
        reg_rd(3'h3);
        check("flags set", rv, 16'h00ff);
        reg_wr(3'h2, 16'h1230);
        reg_rd(3'h2);
        check("index", rv, 16'h1230);
        foreach (rows[i]) begin
            run(CBC_READ, rows[i].m, rows[i].op, 8'h00);
            check("ea", bs.addr, rows[i].ea);
            check("read byte", rs, {1'b1, pat(rows[i].ea)});
        end
        run(CBC_WRITE, extended_mode, 16'h4321, 8'ha5);
        check("write bus", {bs.addr, bs.wdata, bs.rd, bs.wr}, {16'h4321, 8'ha5, 2'b01});
        run(CBC_READ, inherent_mode, 16'h0000, 8'h00);
        check("inherent", {bs.rd, bs.wr, rs[8]}, 16'h0004);
        run(CBC_WRITE, inherent_mode, 16'h0000, 8'h11);
        check("inherent write", {bs.rd, bs.wr, rs[8]}, 16'h0004);
        reg_wr(3'h0, 16'h00fe);
        run(CBC_FETCH, inherent_mode, 16'h0000, 8'h00);
        run(CBC_FETCH, inherent_mode, 16'h0000, 8'h00);
        check("fetch", {bs.addr, rs}, {16'h00ff, 1'b1, pat(16'h00ff)});
        reg_rd(3'h0);
        check("pc after fetch", rv, 16'h0100);
        run(CBC_PUSH, inherent_mode, 16'h0000, 8'h77);
        check("push bus", {bs.addr, bs.wdata, bs.rd, bs.wr}, {16'h00ff, 8'h77, 2'b01});
        reg_rd(3'h1);
        check("sp push", rv, 16'h00fe);
        run(CBC_POP, inherent_mode, 16'h0000, 8'h00);
        check("pop", {bs.addr, rs}, {16'h00ff, 1'b1, pat(16'h00ff)});
        run(CBC_VEC_HI, inherent_mode, 16'h00fe, 8'h00);
        check("vec hi", bs.addr, 16'hfffe);
        run(CBC_VEC_LO, inherent_mode, 16'h00fe, 8'h00);
        check("vec lo", bs.addr, 16'hffff);
        pc = {pat(16'hfffe), pat(16'hffff)};
        reg_rd(3'h0);
        check("pc vector", rv, pc);
        run(CBC_FREE, relative_mode, 16'h0080, 8'h00);
        check("free bus", {bs.addr, bs.rd, bs.wr, rs[8]}, {pc, 3'b100});
        reg_rd(3'h0);
        check("branch back", rv, pc - 16'h0080);
        run(CBC_FREE, relative_mode, 16'hff7f, 8'h00);
        reg_rd(3'h0);
        check("branch fwd", rv, pc - 16'h0001);
        run(CBC_READ, indexed_postinc_mode, 16'h0000, 8'h00);
        run(CBC_READ, indexed_offset_postinc_mode, 16'h0010, 8'h00);
        check("offset postinc", bs.addr, 16'h1241);
        reg_rd(3'h2);
        check("index stepped", rv, 16'h1232);
        reg_rd(3'h4);
        check("last address", rv, 16'h1241);
        reg_rd(3'h5);
        check("cycle count", rv, 16'h0015);
        @(posedge clk_i);
        #1 check("rdata drops", reg_rdata_o, 16'h0000);
        reg_wr(3'h5, 16'h0000);
        reg_rd(3'h5);
        check("count cleared", rv, 16'h0000);
        burst(CBC_FETCH, inherent_mode, 3);
        burst(CBC_PUSH, inherent_mode, 2);
        burst(CBC_POP, inherent_mode, 2);
        burst(CBC_READ, indexed_postinc_mode, 2);
        burst(CBC_FREE, inherent_mode, 2);
        repeat (2) @(posedge clk_i);
        // second reset in mid-run
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1 check("reset again", {mem_o.rd, mem_o.wr, rsp_valid_o, rsp_data_o}, 32'h0000_0000);
        reg_rd(3'h2);
        check("index reset", rv, 16'h0000);
        reg_rd(3'h1);
        check("sp reset", rv, 16'h00ff);
        report_and_stop();
    end
endmodule
